// ### pkg/urb_rx_params.svh
// Offsets, field positions, reset values and sample counts of the receiver.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef URB_RX_PARAMS_SVH
`define URB_RX_PARAMS_SVH

// ==========================================================
// Register offsets
`define URB_ADDR_STATUS 3'h0
`define URB_ADDR_DATA 3'h1
`define URB_ADDR_BAUD 3'h2
`define URB_ADDR_CTRL1 3'h3
`define URB_ADDR_CTRL2 3'h4

// ==========================================================
// Status bit positions
`define URB_ST_RXFULL 5
`define URB_ST_IDLE 4
`define URB_ST_OVERRUN 3
`define URB_ST_NOISE 2
`define URB_ST_FRAMING 1
`define URB_ST_PARITY 0

// ==========================================================
// Control one bit positions
`define URB_C1_R8 7
`define URB_C1_M 4
`define URB_C1_WAKE 3
`define URB_C1_PCE 2
`define URB_C1_PS 1
`define URB_C1_PIE 0

// ==========================================================
// Control two bit positions
`define URB_C2_RIE 5
`define URB_C2_IDLE_IRQ_ENABLE 4
`define URB_C2_TE 3
`define URB_C2_RE 2
`define URB_C2_RWU 1

// ==========================================================
// Baud select fields
`define URB_BAUD_SCP_HI 7
`define URB_BAUD_SCP_LO 6
`define URB_BAUD_SCT_HI 5
`define URB_BAUD_SCT_LO 3
`define URB_BAUD_SCR_HI 2
`define URB_BAUD_SCR_LO 0

// ==========================================================
// Reset values
`define URB_CTRL1_RST 7'h00
`define URB_CTRL2_RST 8'h00
`define URB_BAUD_RST 8'h00

// ==========================================================
// Prescaler values
`define URB_PR_0 4'h1
`define URB_PR_1 4'h3
`define URB_PR_2 4'h4
`define URB_PR_3 4'hD

// ==========================================================
// Sampling
`define URB_OVS 5'h10
`define URB_SMP_EDGE_A 5'h03
`define URB_SMP_EDGE_B 5'h05
`define URB_SMP_EDGE_C 5'h07
`define URB_SMP_MAJ_A 5'h08
`define URB_SMP_MAJ_B 5'h09
`define URB_SMP_MAJ_C 5'h0A
`define URB_LAST_BIT_8 4'h7
`define URB_LAST_BIT_9 4'h8
`define URB_IDLE_SMP_8 8'hA0
`define URB_IDLE_SMP_9 8'hB0

`endif

// ### pkg/urb_pkg.sv
// Types of the receiver and its baud generator.
// Assumes nothing beyond the parameter header.
package urb_pkg;

	// ==========================================================
	// Receive states
	typedef enum logic [2:0] {
		URB_OFF,
		URB_HUNT,
		URB_START,
		URB_DATA,
		URB_STOP
	} urb_rx_state_e;

	// ==========================================================
	// Receiver state
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [2:0] hist;
		urb_rx_state_e state;
		logic [4:0] smp;
		logic [3:0] bitIdx;
		logic [1:0] majLo;
		logic edgeOk;
		logic frameNoise;
		logic pendNoise;
		logic [8:0] shift;
		logic [7:0] idleCnt;
		logic idleArmed;
		logic [8:0] holdBuf;
		logic rxFull;
		logic idleFlag;
		logic overrun;
		logic noiseFlag;
		logic framing;
		logic parityFlag;
		logic statusSeen;
		logic [6:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] baud;
		logic [7:0] rdData;
	} urb_rx_s;

	// ==========================================================
	// Baud generator state
	typedef struct packed {
		logic [10:0] cnt;
		logic tick;
	} urb_baud_s;

endpackage : urb_pkg

// ### rtl/urb_baud_gen.sv
// Baud generator: one-cycle tick at sixteen times the bit rate.
// Assumes a stable selection while enabled.
`timescale 1ns/1ns
`default_nettype none
`include "urb_rx_params.svh"

module urb_baud_gen (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic [1:0] prescaleSel,
	input wire logic [2:0] dividerSel,
	output logic tick
);

	urb_pkg::urb_baud_s s_r;
	urb_pkg::urb_baud_s s_nxt;
	logic [10:0] lastCnt;

	// ==========================================================
	// Prescaler decode
	function automatic logic [3:0] prescaleVal(input logic [1:0] sel);
		case (sel)
			2'h0: prescaleVal = `URB_PR_0;
			2'h1: prescaleVal = `URB_PR_1;
			2'h2: prescaleVal = `URB_PR_2;
			default: prescaleVal = `URB_PR_3;
		endcase
	endfunction : prescaleVal

	// ==========================================================
	// Divider
	always_comb
	begin
		lastCnt = 11'(({7'h00, prescaleVal(prescaleSel)} << dividerSel) - 11'h001);
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!enable)
		begin
			s_nxt.cnt = 11'h000;
		end
		else if (s_r.cnt >= lastCnt)
		begin
			s_nxt.cnt = 11'h000;
			s_nxt.tick = 1'b1;
		end
		else
		begin
			s_nxt.cnt = 11'(s_r.cnt + 11'h001);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule : urb_baud_gen

`default_nettype wire

// ### rtl/urb_rx_top.sv
// Serial receiver with oversampled bit recovery, error flags and wake-up.
// Assumes a one-cycle register port master and a pin from outside the clock.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "urb_rx_params.svh"

module urb_rx_top (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	input wire logic cpuCondCodesI,
	input wire logic serialInPin,
	output logic irqReq,
	output logic txBaudTick
);

	urb_pkg::urb_rx_s s_r;
	urb_pkg::urb_rx_s s_nxt;
	logic rxTick;
	logic sample;
	logic rxOn;
	logic txOn;
	logic wordNine;
	logic mute;
	logic wakeAddr;
	logic [2:0] maj3;
	logic frameDone;
	logic idleDet;
	logic msb;
	logic parFail;
	logic accept;
	logic [7:0] idleThr;
	logic [3:0] lastBit;
	logic [7:0] statusVal;

	// ==========================================================
	// Sample decoding
	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction : majority

	function automatic logic mixed(input logic [2:0] v);
		mixed = (v != 3'b000) && (v != 3'b111);
	endfunction : mixed

	// ==========================================================
	// Baud generators
	assign rxOn = s_r.ctrl2[`URB_C2_RE];
	assign txOn = s_r.ctrl2[`URB_C2_TE];

	urb_baud_gen rxBaud (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(rxOn),
		.prescaleSel(s_r.baud[`URB_BAUD_SCP_HI:`URB_BAUD_SCP_LO]),
		.dividerSel(s_r.baud[`URB_BAUD_SCR_HI:`URB_BAUD_SCR_LO]),
		.tick(rxTick)
	);

	urb_baud_gen txBaud (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(txOn),
		.prescaleSel(s_r.baud[`URB_BAUD_SCP_HI:`URB_BAUD_SCP_LO]),
		.dividerSel(s_r.baud[`URB_BAUD_SCT_HI:`URB_BAUD_SCT_LO]),
		.tick(txBaudTick)
	);

	// ==========================================================
	// Decoded settings
	assign sample = s_r.sync2;
	assign wordNine = s_r.ctrl1[`URB_C1_M];
	assign mute = s_r.ctrl2[`URB_C2_RWU];
	assign wakeAddr = s_r.ctrl1[`URB_C1_WAKE];
	assign maj3 = {s_r.majLo, sample};
	assign lastBit = wordNine ? `URB_LAST_BIT_9 : `URB_LAST_BIT_8;
	assign idleThr = wordNine ? `URB_IDLE_SMP_9 : `URB_IDLE_SMP_8;
	assign msb = wordNine ? s_r.shift[8] : s_r.shift[7];
	assign parFail = (wordNine ? ^s_r.shift[8:0] : ^s_r.shift[7:0])
		!= s_r.ctrl1[`URB_C1_PS];
	assign statusVal = {2'b00, s_r.rxFull, s_r.idleFlag, s_r.overrun,
		s_r.noiseFlag, s_r.framing, s_r.parityFlag};

	// ==========================================================
	// Next state
	always_comb
	begin
		s_nxt = s_r;
		frameDone = 1'b0;
		idleDet = 1'b0;
		accept = 1'b0;
		s_nxt.sync1 = serialInPin;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.rdData = 8'h00;
		if (rxTick)
		begin
			s_nxt.hist = {s_r.hist[1:0], sample};
			if (s_r.state == urb_pkg::URB_START || s_r.state == urb_pkg::URB_DATA
				|| s_r.state == urb_pkg::URB_STOP)
			begin
				s_nxt.smp = (s_r.smp == `URB_OVS) ? 5'h01 : 5'(s_r.smp + 5'h01);
				if (s_r.smp == `URB_SMP_MAJ_A || s_r.smp == `URB_SMP_MAJ_B)
				begin
					s_nxt.majLo = {s_r.majLo[0], sample};
				end
			end
		end

		// ------------------------------------------------------
		// Bit recovery
		case (s_r.state)
			urb_pkg::URB_OFF:
			begin
				s_nxt.idleCnt = 8'h00;
				if (rxOn)
				begin
					s_nxt.state = urb_pkg::URB_HUNT;
				end
			end
			urb_pkg::URB_HUNT:
			begin
				if (rxTick && sample)
				begin
					if (s_r.idleCnt != idleThr)
					begin
						s_nxt.idleCnt = 8'(s_r.idleCnt + 8'h01);
					end
					if (s_r.idleCnt == 8'(idleThr - 8'h01) && s_r.idleArmed)
					begin
						idleDet = 1'b1;
					end
				end
				else if (rxTick && s_r.hist[0])
				begin
					s_nxt.state = urb_pkg::URB_START;
					s_nxt.smp = 5'h02;
					s_nxt.idleCnt = 8'h00;
					s_nxt.bitIdx = 4'h0;
					s_nxt.shift = 9'h000;
					s_nxt.edgeOk = 1'b0;
					s_nxt.frameNoise = (s_r.hist != 3'b111);
				end
				else if (rxTick)
				begin
					s_nxt.idleCnt = 8'h00;
				end
			end
			urb_pkg::URB_START:
			begin
				if (rxTick)
				begin
					if (s_r.smp == `URB_SMP_EDGE_A || s_r.smp == `URB_SMP_EDGE_B
						|| s_r.smp == `URB_SMP_EDGE_C)
					begin
						s_nxt.edgeOk = s_r.edgeOk | sample;
					end
					if (s_r.smp == `URB_SMP_MAJ_C)
					begin
						if (majority(maj3))
						begin
							s_nxt.state = urb_pkg::URB_HUNT;
							s_nxt.pendNoise = s_r.pendNoise | mixed(maj3);
						end
						else
						begin
							s_nxt.frameNoise = s_r.frameNoise | mixed(maj3) | ~s_r.edgeOk;
						end
					end
					if (s_r.smp == `URB_OVS)
					begin
						s_nxt.state = urb_pkg::URB_DATA;
					end
				end
			end
			urb_pkg::URB_DATA:
			begin
				if (rxTick)
				begin
					if (s_r.smp == `URB_SMP_MAJ_C)
					begin
						s_nxt.frameNoise = s_r.frameNoise | mixed(maj3);
						s_nxt.shift[s_r.bitIdx] = majority(maj3);
					end
					if (s_r.smp == `URB_OVS)
					begin
						if (s_r.bitIdx == lastBit)
						begin
							s_nxt.state = urb_pkg::URB_STOP;
						end
						else
						begin
							s_nxt.bitIdx = 4'(s_r.bitIdx + 4'h1);
						end
					end
				end
			end
			urb_pkg::URB_STOP:
			begin
				if (rxTick && s_r.smp == `URB_SMP_MAJ_C)
				begin
					s_nxt.frameNoise = s_r.frameNoise | mixed(maj3);
					frameDone = 1'b1;
					s_nxt.state = urb_pkg::URB_HUNT;
				end
			end
			default:
			begin
				s_nxt.state = urb_pkg::URB_OFF;
			end
		endcase
		if (!rxOn)
		begin
			s_nxt.state = urb_pkg::URB_OFF;
		end

		// ------------------------------------------------------
		// Register port: reads and the clearing sequence
		if (rdStb)
		begin
			case (addr)
				`URB_ADDR_STATUS:
				begin
					s_nxt.rdData = statusVal;
					s_nxt.statusSeen = 1'b1;
				end
				`URB_ADDR_DATA:
				begin
					s_nxt.rdData = s_r.holdBuf[7:0];
					if (s_r.statusSeen)
					begin
						s_nxt.statusSeen = 1'b0;
						s_nxt.rxFull = 1'b0;
						s_nxt.idleFlag = 1'b0;
						s_nxt.overrun = 1'b0;
						s_nxt.noiseFlag = 1'b0;
						s_nxt.framing = 1'b0;
						s_nxt.parityFlag = 1'b0;
					end
				end
				`URB_ADDR_BAUD: s_nxt.rdData = s_r.baud;
				`URB_ADDR_CTRL1: s_nxt.rdData = {s_r.holdBuf[8], s_r.ctrl1};
				`URB_ADDR_CTRL2: s_nxt.rdData = s_r.ctrl2;
				default: s_nxt.rdData = 8'h00;
			endcase
		end

		// ------------------------------------------------------
		// Character and idle completion; sets win over the clear
		if (idleDet)
		begin
			s_nxt.idleArmed = 1'b0;
			if (mute)
			begin
				// idle wake, idle flag stays clear
				if (!wakeAddr)
				begin
					s_nxt.ctrl2[`URB_C2_RWU] = 1'b0;
				end
			end
			else if (s_r.rxFull)
			begin
				s_nxt.overrun = 1'b1;
			end
			else
			begin
				s_nxt.holdBuf = 9'h1FF;
				s_nxt.rxFull = 1'b1;
				s_nxt.idleFlag = 1'b1;
			end
		end
		if (frameDone)
		begin
			if (mute && wakeAddr && msb)
			begin
				s_nxt.ctrl2[`URB_C2_RWU] = 1'b0;
			end
			accept = !mute || (wakeAddr && msb);
			if (accept && s_r.rxFull)
			begin
				s_nxt.overrun = 1'b1;
			end
			else if (accept)
			begin
				s_nxt.holdBuf = s_r.shift;
				s_nxt.rxFull = 1'b1;
				s_nxt.idleArmed = 1'b1;
				s_nxt.noiseFlag = s_r.frameNoise | mixed(maj3) | s_r.pendNoise;
				s_nxt.pendNoise = 1'b0;
				s_nxt.framing = ~majority(maj3);
				s_nxt.parityFlag = s_r.ctrl1[`URB_C1_PCE] & parFail;
			end
		end

		// ------------------------------------------------------
		// Register port: writes, after hardware mute release
		if (wrStb)
		begin
			case (addr)
				`URB_ADDR_BAUD: s_nxt.baud = wrData;
				`URB_ADDR_CTRL1: s_nxt.ctrl1 = wrData[6:0];
				// a write here overrides a wake
				`URB_ADDR_CTRL2: s_nxt.ctrl2 = wrData;
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_r <= '0;
			s_r.sync1 <= 1'b1;
			s_r.sync2 <= 1'b1;
			// History at line idle, so no false start edge
			s_r.hist <= 3'h7;
			s_r.state <= urb_pkg::URB_OFF;
			s_r.ctrl1 <= `URB_CTRL1_RST;
			s_r.ctrl2 <= `URB_CTRL2_RST;
			s_r.baud <= `URB_BAUD_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign rdData = s_r.rdData;
	assign irqReq = !cpuCondCodesI && !mute && (
		(s_r.ctrl2[`URB_C2_RIE] && (s_r.rxFull || s_r.overrun))
		|| (s_r.ctrl2[`URB_C2_IDLE_IRQ_ENABLE] && s_r.idleFlag)
		|| (s_r.ctrl1[`URB_C1_PIE] && s_r.parityFlag));

endmodule : urb_rx_top

`default_nettype wire

// ### sim/urb_serial_peer.sv
// Serial peer: sends NRZ frames on the receive pin.
// Assumes the sample tick runs every clock, so a bit lasts sixteen clocks.
`timescale 1ns/1ns
`default_nettype none

module urb_serial_peer #(
	parameter int BIT_CLKS = 16
) (
	input wire logic ref_clk,
	output logic serialInPin
);
	// Cleared by a scenario to send a start bit with no high mark
	logic edgeMark = 1'b1;

	initial serialInPin = 1'b1;

	task automatic hold_bit(input logic b, input int n);
		serialInPin <= b;
		repeat (n) @(posedge ref_clk);
	endtask : hold_bit

	task automatic put_bit(input logic b);
		hold_bit(b, BIT_CLKS);
	endtask : put_bit

	// ==========================================================
	// Frame sender
	// start, LSB first, stop
	task automatic send_frame(input logic [8:0] word, input int nBits, input logic stopLvl);
		// start bit carries one high sample at five
		if (edgeMark)
		begin
			hold_bit(1'b0, 4);
			hold_bit(1'b1, 1);
			hold_bit(1'b0, BIT_CLKS - 5);
		end
		else
			put_bit(1'b0);
		for (int i = 0; i < nBits; i++)
			put_bit(word[i]);
		put_bit(stopLvl);
		if (!stopLvl)
			put_bit(1'b1);
	endtask : send_frame
endmodule : urb_serial_peer
`default_nettype wire

// ### sim/urb_rx_assertions.sv
// Checker of the receiver's register port, interrupt and baud tick.
// Assumes it is bound to urb_rx_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module urb_rx_assertions (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] rdData,
	input wire logic cpuCondCodesI,
	input wire logic serialInPin,
	input wire logic irqReq,
	input wire logic txBaudTick
);
	logic [7:0] baudSh_r;
	logic [7:0] ctrl2Sh_r;
	logic pieSh_r;

	// ==========================================================
	// Shadows of written controls
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			baudSh_r <= 8'h00;
			ctrl2Sh_r <= 8'h00;
			pieSh_r <= 1'b0;
		end
		else if (wrStb)
		begin
			if (addr == 3'h2)
				baudSh_r <= wrData;
			if (addr == 3'h4)
				ctrl2Sh_r <= wrData;
			if (addr == 3'h3)
				pieSh_r <= wrData[0];
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_rd(logic [2:0] a);
		rdStb && addr == a;
	endsequence
	sequence s_te_fast;
		(ctrl2Sh_r[3] && baudSh_r == 8'h00) [*4];
	endsequence

	// ==========================================================
	// Properties
	a_rd_idle_zero: assert property (!rdStb |=> rdData == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_rd: assert property (rdStb && addr > 3'h4 |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_status_top: assert property (s_rd(3'h0) |=> rdData[7:6] == 2'b00)
		else $error("status top bits set");
	a_baud_back: assert property (s_rd(3'h2) |=> rdData == $past(baudSh_r))
		else $error("baud readback differs");
	a_ctrl2_back: assert property (s_rd(3'h4) |=> rdData[5:2] == $past(ctrl2Sh_r[5:2]))
		else $error("control two readback differs");
	a_mask_irq: assert property (cpuCondCodesI |-> !irqReq)
		else $error("interrupt while masked");
	a_irq_cause: assert property (irqReq |-> ctrl2Sh_r[5] || ctrl2Sh_r[4] || pieSh_r)
		else $error("interrupt without enable");
	a_tick_off: assert property (!ctrl2Sh_r[3] && !$past(ctrl2Sh_r[3]) |-> !txBaudTick)
		else $error("baud tick while off");
	a_tick_rate: assert property (s_te_fast |-> txBaudTick)
		else $error("baud tick missing at divide one");
endmodule : urb_rx_assertions

bind urb_rx_top urb_rx_assertions i_chk (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.addr(addr),
	.wrData(wrData),
	.wrStb(wrStb),
	.rdStb(rdStb),
	.rdData(rdData),
	.cpuCondCodesI(cpuCondCodesI),
	.serialInPin(serialInPin),
	.irqReq(irqReq),
	.txBaudTick(txBaudTick)
);
`default_nettype wire

// ### sim/urb_rx_top_tb.sv
// Testbench of the receiver: register tasks, serial peer, scenarios.
// Assumes baud select zero, so one sample tick every clock.
`timescale 1ns/1ns
`default_nettype none

module urb_rx_top_tb;
	logic ref_clk;
	logic rst_b;
	logic [2:0] addr;
	logic [7:0] wrData;
	logic wrStb;
	logic rdStb;
	wire logic [7:0] rdData;
	logic cpuCondCodesI;
	wire logic serialInPin;
	wire logic irqReq;
	wire logic txBaudTick;
	int errorCnt;
	int checkCount;
	logic [7:0] rdVal;

	urb_rx_top i_dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.addr(addr),
		.wrData(wrData),
		.wrStb(wrStb),
		.rdStb(rdStb),
		.rdData(rdData),
		.cpuCondCodesI(cpuCondCodesI),
		.serialInPin(serialInPin),
		.irqReq(irqReq),
		.txBaudTick(txBaudTick)
	);

	urb_serial_peer i_peer (
		.ref_clk(ref_clk),
		.serialInPin(serialInPin)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Bus and comparison tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge ref_clk);
		wrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge ref_clk);
		rdStb <= 1'b0;
		#1 rdVal = rdData;
	endtask : rd

	task automatic drain();
		repeat (200) @(posedge ref_clk);
		rd(3'h0);
		rd(3'h1);
	endtask : drain

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Scenarios
	task automatic t_basic();
		wr(3'h2, 8'h00); // baud set before enabling
		wr(3'h4, 8'h08);
		i_peer.send_frame(9'h011, 8, 1'b1);
		rd(3'h0); check("status off", rdVal, 8'h00);
		wr(3'h4, 8'h2C);
		i_peer.send_frame(9'h0A5, 8, 1'b1);
		rd(3'h0); check("status", rdVal, 8'h20);
		check("irq masked", {7'h00, irqReq}, 8'h00);
		@(posedge ref_clk) cpuCondCodesI <= 1'b0;
		#1 check("irq", {7'h00, irqReq}, 8'h01);
		rd(3'h1); check("data", rdVal, 8'hA5);
		rd(3'h0); check("status clr", rdVal, 8'h00);
		check("irq clr", {7'h00, irqReq}, 8'h00);
		$display("basic done");
	endtask : t_basic

	task automatic t_idle();
		wr(3'h4, 8'h1C);
		repeat (200) @(posedge ref_clk);
		rd(3'h0); check("idle status", rdVal, 8'h30);
		check("idle irq", {7'h00, irqReq}, 8'h01);
		rd(3'h1); check("idle data", rdVal, 8'hFF);
		rd(3'h0); check("idle clr", rdVal, 8'h00);
		$display("idle done");
	endtask : t_idle

	task automatic t_overrun();
		wr(3'h4, 8'h2C);
		i_peer.send_frame(9'h03C, 8, 1'b1);
		i_peer.send_frame(9'h0C3, 8, 1'b1);
		rd(3'h0); check("ovr status", rdVal, 8'h28);
		rd(3'h1); check("ovr data", rdVal, 8'h3C);
		rd(3'h0); check("ovr clr", rdVal, 8'h00);
		$display("overrun done");
	endtask : t_overrun

	task automatic t_framing();
		drain();
		i_peer.send_frame(9'h055, 8, 1'b0);
		rd(3'h0); check("fe status", rdVal, 8'h22);
		rd(3'h1); check("fe data", rdVal, 8'h55);
		wr(3'h3, 8'h10);
		i_peer.send_frame(9'h15A, 9, 1'b1);
		rd(3'h0); check("nine status", rdVal, 8'h20);
		rd(3'h3); check("nine bit8", rdVal, 8'h90);
		rd(3'h1); check("nine data", rdVal, 8'h5A);
		$display("framing done");
	endtask : t_framing

	task automatic par_case(input logic [7:0] c1, input logic [7:0] w, input logic [7:0] st);
		wr(3'h3, c1);
		i_peer.send_frame({1'b0, w}, 8, 1'b1);
		rd(3'h0); check("par status", rdVal, st);
		check("par irq", {7'h00, irqReq}, {7'h00, st[0]});
		rd(3'h1); check("par data", rdVal, w);
	endtask : par_case

	task automatic t_parity();
		drain();
		wr(3'h4, 8'h0C);
		par_case(8'h05, 8'h07, 8'h21);
		par_case(8'h05, 8'h87, 8'h20);
		par_case(8'h07, 8'h07, 8'h20);
		par_case(8'h07, 8'h87, 8'h21);
		$display("parity done");
	endtask : t_parity

	task automatic t_mute();
		drain();
		wr(3'h3, 8'h08);
		wr(3'h4, 8'h2E);
		// no control two write while muted
		i_peer.send_frame(9'h012, 8, 1'b1);
		rd(3'h0); check("mute status", rdVal, 8'h00);
		check("mute irq", {7'h00, irqReq}, 8'h00);
		i_peer.send_frame(9'h092, 8, 1'b1);
		rd(3'h0); check("wake status", rdVal, 8'h20);
		rd(3'h4); check("wake ctrl", rdVal, 8'h2C);
		rd(3'h1); check("wake data", rdVal, 8'h92);
		$display("mute done");
	endtask : t_mute

	task automatic t_noise();
		i_peer.edgeMark = 1'b0;
		i_peer.send_frame(9'h033, 8, 1'b1);
		i_peer.edgeMark = 1'b1;
		rd(3'h0); check("noise status", rdVal, 8'h24);
		rd(3'h1); check("noise data", rdVal, 8'h33);
		$display("noise done");
	endtask : t_noise

	task automatic rate_case(input logic [7:0] sel, input int span, input int expTicks);
		int nTick;
		nTick = 0;
		wr(3'h4, 8'h00);
		wr(3'h2, sel); // rates changed only while off
		wr(3'h4, 8'h08);
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < span; i++)
		begin
			@(negedge ref_clk);
			nTick += int'(txBaudTick);
		end
		check("tx ticks", 8'(nTick), 8'(expTicks));
	endtask : rate_case

	task automatic t_rate();
		rate_case(8'h48, 60, 10);
		rate_case(8'hC0, 65, 5);
		$display("rate done");
	endtask : t_rate

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		rst_b = 1'b0;
		addr = 3'h0;
		wrData = 8'h00;
		wrStb = 1'b0;
		rdStb = 1'b0;
		cpuCondCodesI = 1'b1;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_basic();
		t_idle();
		t_overrun();
		t_framing();
		t_parity();
		t_mute();
		t_noise();
		t_rate();
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		tally_and_finish();
	end
endmodule : urb_rx_top_tb
`default_nettype wire
